// ---- logic/hwd_defs.svh ----
// Functional notes
// - 14-bit counter plus write-only restart register
// - watchdog disabled after any reset
// - write 1E then E1 to A6 arms
// - enabled counter advances every machine cycle at select 0; every 2^n at select n
// - only resets disable; writes never do
// - repeated sequence restarts count from zero
// - count reaching 16383 resets the device
// - overflow drives 96-oscillator-period high reset pulse
// - restart write-only; counter not software visible
// - extra 2^7 prescaler, selected at A7
// - machine cycle 12 clocks, 6 double-speed
// - pin high two machine cycles resets device
`ifndef HWD_DEFS_SVH
`define HWD_DEFS_SVH

`define HWD_RESTART_ADDR 8'hA6
`define HWD_SELECT_ADDR 8'hA7
`define HWD_KEY_FIRST 8'h1E
`define HWD_KEY_SECOND 8'hE1
`define HWD_COUNT_WIDTH 14
`define HWD_COUNT_ZERO 14'h0000
`define HWD_COUNT_ONE 14'h0001
`define HWD_COUNT_LAST 14'h3FFE
`define HWD_PRESC_WIDTH 7
`define HWD_PRESC_ZERO 7'h00
`define HWD_PRESC_ONE 7'h01
`define HWD_SEL_WIDTH 3
`define HWD_SEL_RESET 3'h0
`define HWD_READ_ZERO 8'h00
`define HWD_SEL_PAD 5'h00
`define HWD_MC_CLOCKS_STD 4'hC
`define HWD_MC_CLOCKS_X2 4'h6
`define HWD_MC_ZERO 4'h0
`define HWD_MC_ONE 4'h1
`define HWD_OSC_PER_CLK 1
`define HWD_PULSE_TOSC 96
`define HWD_PULSE_CYCLES (`HWD_PULSE_TOSC * `HWD_OSC_PER_CLK)
`define HWD_PULSE_ZERO 7'h00
`define HWD_PULSE_ONE 7'h01
`define HWD_HOLD_MC 2'h2
`define HWD_HOLD_ZERO 2'h0
`define HWD_HOLD_ONE 2'h1

`endif

// ---- logic/hwd_pkg.sv ----
package hwd_pkg;

  // restart sequence detector
  typedef enum logic [0:0] {
    HWD_SEQ_IDLE,
    HWD_SEQ_FIRST
  } hwd_seq_t;

  // timeout select field and pulse length counter
  typedef logic [2:0] hwd_sel_t;
  typedef logic [6:0] hwd_pulse_t;

endpackage

// ---- logic/hwd_mc_tick.sv ----
`timescale 1ns/100ps
`include "hwd_defs.svh"

module hwd_mc_tick
  import hwd_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic double_speed_bit,
  output logic mc_tick
);

  logic [3:0] phase;
  wire logic [3:0] mc_len;
  wire logic phase_end;
  wire logic [3:0] next_phase;

  assign mc_len = double_speed_bit ? `HWD_MC_CLOCKS_X2 : `HWD_MC_CLOCKS_STD;
  // >= rather than == so a mode change mid-cycle never skips a wrap
  assign phase_end = (phase >= (mc_len - `HWD_MC_ONE));
  assign next_phase = phase_end ? `HWD_MC_ZERO : (phase + `HWD_MC_ONE);

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      phase <= `HWD_MC_ZERO;
      mc_tick <= 1'b0;
    end else begin
      phase <= next_phase;
      mc_tick <= phase_end;
    end
  end

endmodule // hwd_mc_tick

// ---- logic/hwd_watchdog.sv ----
`timescale 1ns/100ps
`include "hwd_defs.svh"

module hwd_watchdog
  import hwd_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic double_speed_bit,
  input wire logic rst_pin_in,
  output logic [7:0] sfr_rdata,
  output logic rst_pin_out,
  output logic rst_pin_oe_n,
  output logic core_reset,
  output logic watchdog_active
);

  // true when a strobe targets the given special register
  function automatic logic hits(input logic strobe, input logic [7:0] addr,
                                input logic [7:0] target);
    hits = strobe && (addr == target);
  endfunction

  // ------------------------------------------------------------------
  // machine cycle timebase
  // ------------------------------------------------------------------
  wire logic mc_tick;

  hwd_mc_tick u_tick (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .double_speed_bit(double_speed_bit),
    .mc_tick(mc_tick)
  );

  // ------------------------------------------------------------------
  // reset pin qualification
  // ------------------------------------------------------------------
  logic pin_meta;
  logic pin_sync;
  logic [1:0] hold_mc;
  wire logic [1:0] next_hold_mc;
  wire logic hold_done;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
    end else begin
      pin_meta <= rst_pin_in;
      pin_sync <= pin_meta;
    end
  end

  // the pin must stay high across two full machine ticks
  assign hold_done = (hold_mc == `HWD_HOLD_MC);
  assign next_hold_mc = !pin_sync ? `HWD_HOLD_ZERO :
                        (mc_tick && !hold_done) ? (hold_mc + `HWD_HOLD_ONE) :
                        hold_mc;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      hold_mc <= `HWD_HOLD_ZERO;
      core_reset <= 1'b0;
    end else begin
      hold_mc <= next_hold_mc;
      core_reset <= (next_hold_mc == `HWD_HOLD_MC);
    end
  end

  // ------------------------------------------------------------------
  // register access
  // ------------------------------------------------------------------
  wire logic wr_restart;
  wire logic wr_select;
  wire logic rd_select;
  wire logic first_key;
  wire logic second_key;

  assign wr_restart = hits(sfr_wr, sfr_addr, `HWD_RESTART_ADDR);
  assign wr_select = hits(sfr_wr, sfr_addr, `HWD_SELECT_ADDR);
  assign rd_select = hits(sfr_rd, sfr_addr, `HWD_SELECT_ADDR);
  assign first_key = (sfr_wdata == `HWD_KEY_FIRST);
  assign second_key = (sfr_wdata == `HWD_KEY_SECOND);

  hwd_sel_t sel;

  // a qualified pin reset also returns the prescale choice to its default
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sel <= `HWD_SEL_RESET;
    end else if (core_reset) begin
      sel <= `HWD_SEL_RESET;
    end else if (wr_select) begin
      sel <= sfr_wdata[`HWD_SEL_WIDTH-1:0];
    end
  end

  // restart register reads as zero; counter has no read path
  wire logic [7:0] next_rdata;

  assign next_rdata = rd_select ? {`HWD_SEL_PAD, sel} : `HWD_READ_ZERO;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sfr_rdata <= `HWD_READ_ZERO;
    end else begin
      sfr_rdata <= next_rdata;
    end
  end

  // ------------------------------------------------------------------
  // key sequence detector
  // ------------------------------------------------------------------
  hwd_seq_t seq;
  hwd_seq_t next_seq;
  logic key_done;

  always_comb begin
    next_seq = seq;
    key_done = 1'b0;
    if (wr_restart) begin
      case (seq)
        HWD_SEQ_IDLE: begin
          next_seq = first_key ? HWD_SEQ_FIRST : HWD_SEQ_IDLE;
        end
        HWD_SEQ_FIRST: begin
          // any other byte drops the half-sequence; a fresh 1E restarts it
          key_done = second_key;
          next_seq = first_key ? HWD_SEQ_FIRST : HWD_SEQ_IDLE;
        end
        default: begin
          next_seq = HWD_SEQ_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // counter, prescaler, overflow
  // ------------------------------------------------------------------
  logic enabled;
  logic [`HWD_COUNT_WIDTH-1:0] count;
  logic [`HWD_PRESC_WIDTH-1:0] presc;
  hwd_pulse_t pulse_left;

  wire logic [`HWD_PRESC_WIDTH-1:0] presc_last;
  wire logic presc_wrap;
  wire logic count_step;
  wire logic overflow;
  wire logic pulse_busy;
  wire logic wd_clear;

  // select n gives 2^n machine cycles per count, n up to 7
  assign presc_last = `HWD_PRESC_WIDTH'((8'h01 << sel) - 8'h01);
  assign presc_wrap = (presc >= presc_last);
  assign count_step = enabled && mc_tick && presc_wrap;
  // fires as the count lands on 16383
  assign overflow = count_step && (count == `HWD_COUNT_LAST);
  assign pulse_busy = (pulse_left != `HWD_PULSE_ZERO);
  // both the pin reset and the block's own overflow disarm it
  assign wd_clear = core_reset || overflow || pulse_busy;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      seq <= HWD_SEQ_IDLE;
    end else if (wd_clear) begin
      seq <= HWD_SEQ_IDLE;
    end else begin
      seq <= next_seq;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      enabled <= 1'b0;
    end else if (wd_clear) begin
      enabled <= 1'b0;
    end else if (key_done) begin
      enabled <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      count <= `HWD_COUNT_ZERO;
      presc <= `HWD_PRESC_ZERO;
    end else if (wd_clear || key_done) begin
      // servicing also realigns the prescaler, so a full period follows
      count <= `HWD_COUNT_ZERO;
      presc <= `HWD_PRESC_ZERO;
    end else if (enabled && mc_tick) begin
      presc <= presc_wrap ? `HWD_PRESC_ZERO : (presc + `HWD_PRESC_ONE);
      if (presc_wrap) begin
        count <= count + `HWD_COUNT_ONE;
      end
    end
  end

  // ------------------------------------------------------------------
  // reset pulse driver
  // ------------------------------------------------------------------
  // 96 clocks covers the two machine cycles the pin needs in either mode
  wire hwd_pulse_t next_pulse_left;

  assign next_pulse_left = overflow ? hwd_pulse_t'(`HWD_PULSE_CYCLES) :
                           pulse_busy ? (pulse_left - `HWD_PULSE_ONE) :
                           `HWD_PULSE_ZERO;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pulse_left <= `HWD_PULSE_ZERO;
      rst_pin_out <= 1'b0;
      rst_pin_oe_n <= 1'b1;
    end else begin
      pulse_left <= next_pulse_left;
      rst_pin_out <= (next_pulse_left != `HWD_PULSE_ZERO);
      rst_pin_oe_n <= (next_pulse_left == `HWD_PULSE_ZERO);
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      watchdog_active <= 1'b0;
    end else begin
      watchdog_active <= (enabled && !wd_clear) || (key_done && !wd_clear);
    end
  end

endmodule // hwd_watchdog

// ---- testbench/hwd_watchdog_checker.sv ----
`timescale 1ns/100ps
module hwd_watchdog_checker (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic double_speed_bit,
  input wire logic rst_pin_in,
  input wire logic [7:0] sfr_rdata,
  input wire logic rst_pin_out,
  input wire logic rst_pin_oe_n,
  input wire logic core_reset,
  input wire logic watchdog_active
);
  logic [7:0] hi_cnt;
  wire key1 = sfr_wr && sfr_addr == 8'hA6 && sfr_wdata == 8'h1E;
  wire key2 = sfr_wr && sfr_addr == 8'hA6 && sfr_wdata == 8'hE1;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn)
      hi_cnt <= 8'h00;
    else
      hi_cnt <= rst_pin_out ? hi_cnt + 8'h01 : 8'h00;
  end
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  a_pulse_drives_pin: assert property (rst_pin_out |-> !rst_pin_oe_n)
    else $error("pulse not driven");
  a_pulse_exact_length: assert property ($fell(rst_pin_out) |-> hi_cnt == 8'h60)
    else $error("pulse length");
  a_arm_sets_active: assert property (key1 ##1 (key2 && !core_reset && !rst_pin_out)
    |-> ##[1:2] watchdog_active) else $error("arm missed");
  a_active_only_reset: assert property ($fell(watchdog_active)
    |-> rst_pin_out || core_reset || $past(core_reset)) else $error("disabled by write");
  a_pulse_needs_arm: assert property ($rose(rst_pin_out) |-> $past(watchdog_active))
    else $error("pulse while idle");
  a_restart_read_zero: assert property (sfr_rd && sfr_addr == 8'hA6
    |=> sfr_rdata == 8'h00) else $error("restart readable");
  a_select_upper_zero: assert property (sfr_rd && sfr_addr == 8'hA7
    |=> sfr_rdata[7:3] == 5'h00) else $error("select upper bits");
  // pin must have been high at two sample points, 3 and 8 cycles before the rise
  a_core_reset_qual: assert property ($rose(core_reset)
    |-> $past(rst_pin_in, 3) && $past(rst_pin_in, 8)) else $error("short pin reset");
  cover property (key1 ##1 key2);
  cover property ($rose(rst_pin_out));
  cover property ($rose(core_reset));
endmodule // hwd_watchdog_checker

bind hwd_watchdog hwd_watchdog_checker i_chk (.clk_sys(clk_sys), .rstn(rstn),
  .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
  .double_speed_bit(double_speed_bit), .rst_pin_in(rst_pin_in), .sfr_rdata(sfr_rdata),
  .rst_pin_out(rst_pin_out), .rst_pin_oe_n(rst_pin_oe_n), .core_reset(core_reset),
  .watchdog_active(watchdog_active));

// ---- testbench/test_hardware_watchdog_timer.sv ----
`timescale 1ns/100ps
module test_hardware_watchdog_timer
  import hwd_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  // fast machine cycle keeps the full timeout inside the run budget
  logic double_speed_bit = 1'b1;
  logic ext_drv = 1'b0;
  logic [7:0] sfr_rdata;
  logic rst_pin_out, rst_pin_oe_n, core_reset, watchdog_active, seen_core;
  // pin follows ext_drv when the watchdog does not drive it
  wire rst_pin = !rst_pin_oe_n ? rst_pin_out : ext_drv;
  int mismatches = 0;
  int compares = 0;
  int cycles = 0;
  int n;
  hwd_watchdog i_dut (.clk_sys(clk_sys), .rstn(rstn), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .double_speed_bit(double_speed_bit), .rst_pin_in(rst_pin), .sfr_rdata(sfr_rdata),
    .rst_pin_out(rst_pin_out), .rst_pin_oe_n(rst_pin_oe_n), .core_reset(core_reset),
    .watchdog_active(watchdog_active));
  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic gap(input int k);
    repeat (k) @(negedge clk_sys);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk_sys);
    sfr_wr = 1'b0;
  endtask
  // key pair back to back, second byte on the very next edge
  task automatic wr_key;
    @(negedge clk_sys);
    sfr_addr = 8'hA6;
    sfr_wdata = 8'h1E;
    sfr_wr = 1'b1;
    @(negedge clk_sys);
    sfr_wdata = 8'hE1;
    @(negedge clk_sys);
    sfr_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk_sys);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clk_sys);
    sfr_rd = 1'b0;
    chk("read data", {8'h00, sfr_rdata}, {8'h00, exp});
  endtask
  task automatic results;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 99900) begin
      mismatches++;
      results();
    end
  end
  initial begin
    gap(12);
    rstn = 1'b1;
    gap(2);
    chk("active", watchdog_active, 1'b0);
    rd(8'hA6, 8'h00);
    wr(8'hA7, 8'hFF);
    rd(8'hA7, 8'h07);
    rd(8'h55, 8'h00);
    wr(8'hA6, 8'hE1);
    wr(8'hA6, 8'h1E);
    wr(8'hA6, 8'h55);
    wr(8'hA6, 8'hE1);
    gap(3);
    chk("active", watchdog_active, 1'b0);
    wr(8'hA6, 8'h1E);
    wr(8'hA7, 8'h00);
    wr(8'hA6, 8'hE1);
    gap(3);
    chk("active", watchdog_active, 1'b1);
    wr(8'hA6, 8'h00);
    gap(200);
    chk("active", watchdog_active, 1'b1);
    $display("test arm done");
    wr_key();
    for (n = 0; rst_pin_oe_n !== 1'b0 && n < 100000; n++)
      @(negedge clk_sys);
    // 16383 machine cycles of 6 clocks, one machine cycle of phase slack
    chk("timeout", n > 98291 && n < 98311, 1'b1);
    seen_core = 1'b0;
    for (n = 0; rst_pin_oe_n === 1'b0 && n < 200; n++) begin
      @(negedge clk_sys);
      seen_core |= core_reset;
    end
    chk("pulse", n[15:0], 16'h0060);
    chk("core reset", seen_core, 1'b1);
    gap(10);
    chk("active", watchdog_active, 1'b0);
    $display("test overflow done");
    wr(8'hA7, 8'h05);
    wr_key();
    chk("active", watchdog_active, 1'b1);
    // twelve clocks of pin high never span two standard machine ticks
    double_speed_bit = 1'b0;
    seen_core = 1'b0;
    ext_drv = 1'b1;
    for (n = 0; n < 16; n++) begin
      @(negedge clk_sys);
      if (n == 11)
        ext_drv = 1'b0;
      seen_core |= core_reset;
    end
    chk("short pin", seen_core, 1'b0);
    chk("active", watchdog_active, 1'b1);
    double_speed_bit = 1'b1;
    ext_drv = 1'b1;
    gap(30);
    chk("core reset", core_reset, 1'b1);
    ext_drv = 1'b0;
    gap(10);
    chk("active", watchdog_active, 1'b0);
    rd(8'hA7, 8'h00);
    $display("test pin reset done");
    results();
  end
endmodule // test_hardware_watchdog_timer
